// ---- hw/ocp_output_compare_pwm.sv ----
// ocp_output_compare_pwm: one pwm compare channel with apb register access
// assumes: timer prescaler ticks are one-cycle pulses on this clock, fault
// and idle inputs are synchronous to this clock
`timescale 1ns/1ps

// How it works
// - edge or center pwm; duty held in internal unaddressable latches.
// - period register value N gives N plus one time base counts.
// - compare registers writable anytime; latched only at period match.
// - all compares and period zero keep the pin low.
// - secondary compare above period keeps the pin high.
// - timer source uses that timer's prescaler tick, not its count.
// - bit 13 halts the channel during cpu idle; clear keeps running.
// - three-bit time base select: 111 clock, 100 timer1, 011-000 timers 5-2.
// - bit 9 enables the comparator fault input.
// - bit 8 enables fault pin b.
// - bit 7 enables fault pin a.
// - bits 6 and 5 flag comparator and pin b faults; software read/write.
// - fault enables and flags act only in modes 111 and 110.
// - comparator 1 serves channels 1-3, 2 serves 4-6, 3 serves 7-9.
// - mode 111 center pwm, 110 edge pwm, 000 disables the channel.
// - bit 4 flags a fault on fault pin a.
// - fault exit after removal plus flag clear, or plus new period.
// - during a fault the pin takes the fault output level.
module ocp_output_compare_pwm
#(
  parameter int CHANNEL_INDEX = 1
)
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // time base ticks and cpu state
  input wire logic [3:0] timerPrescaleTick,
  input wire logic timerOnePrescaleTick,
  input wire logic cpuIdle,
  // fault sources
  input wire logic faultInputA,
  input wire logic faultInputB,
  input wire logic [2:0] comparatorOut,
  // pwm pin
  output logic compareOutputPin
);
  import ocp_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0] ctrlOne;
    logic [15:0] ctrlTwo;
    logic [15:0] primaryCompareReg;
    logic [15:0] secondaryCompareReg;
    logic [15:0] timerPeriodReg;
    logic [15:0] primaryLatch;
    logic [15:0] secondaryLatch;
    logic [15:0] channelCount;
    ocp_fault_t faultState;
    logic pinOut;
    logic ready;
    logic slvErr;
    logic [31:0] rdData;
  } ocp_state_t;

  ocp_state_t state_ff;
  ocp_state_t nxt_state;

  // ==========================================================
  // helpers
  function automatic logic isPwmMode(input logic [2:0] mode);
    isPwmMode = (mode == OCP_MODE_EDGE) || (mode == OCP_MODE_CENTER);
  endfunction

  // comparator group of this channel, three channels per comparator
  function automatic logic [1:0] compGroup(input int idx);
    int grp;
    grp = (idx - 1) / 3;
    compGroup = grp[1:0];
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == OCP_OFS_CTRL_ONE) || (addr == OCP_OFS_CTRL_TWO) ||
             (addr == OCP_OFS_PRIMARY) || (addr == OCP_OFS_SECONDARY) ||
             (addr == OCP_OFS_PERIOD) || (addr == OCP_OFS_STATUS);
  endfunction

  // ==========================================================
  // combinational view of control fields
  logic [2:0] modeField;
  logic [2:0] timeBaseSelect;
  logic pwmMode;
  logic timeTick;
  logic running;
  logic periodMatch;
  logic comparatorFault;
  logic [2:0] faultHit;
  logic anyFault;
  logic pwmLevel;
  logic [15:0] shownCount;
  logic busWrite;
  logic busAccess;
  logic [15:0] wrData;

  always_comb
  begin
    modeField = state_ff.ctrlOne[2:0];
    timeBaseSelect = state_ff.ctrlOne[OCP_C1_TSEL_LO +: 3];
    pwmMode = isPwmMode(modeField);
    comparatorFault = 1'b0;
    if (compGroup(CHANNEL_INDEX) < 2'h3)
    begin
      comparatorFault = comparatorOut[compGroup(CHANNEL_INDEX)];
    end
    case (timeBaseSelect)
      OCP_TSEL_PERIPH: timeTick = 1'b1;
      OCP_TSEL_TIMER1: timeTick = timerOnePrescaleTick;
      default:
      begin
        if (timeBaseSelect <= OCP_TSEL_TIMER5)
        begin
          timeTick = timerPrescaleTick[timeBaseSelect[1:0]];
        end
        else
        begin
          timeTick = 1'b0;
        end
      end
    endcase
    running = (modeField != OCP_MODE_OFF) &&
              !(state_ff.ctrlOne[OCP_C1_IDLE_HALT] && cpuIdle);
    periodMatch = running && timeTick &&
                  (state_ff.channelCount == state_ff.timerPeriodReg);
    faultHit[2] = pwmMode && state_ff.ctrlOne[OCP_C1_EN_COMP] && comparatorFault;
    faultHit[1] = pwmMode && state_ff.ctrlOne[OCP_C1_EN_PIN_B] && faultInputB;
    faultHit[0] = pwmMode && state_ff.ctrlOne[OCP_C1_EN_PIN_A] && faultInputA;
    anyFault = |faultHit;
    // count standing after this edge, so the pin moves with the count
    shownCount = state_ff.channelCount;
    if (running && timeTick)
    begin
      shownCount = state_ff.channelCount + 16'h0001;
    end
    if (state_ff.secondaryLatch > state_ff.timerPeriodReg)
    begin
      pwmLevel = 1'b1;
    end
    else if (modeField == OCP_MODE_CENTER)
    begin
      pwmLevel = (shownCount >= state_ff.primaryLatch) &&
                 (shownCount < state_ff.secondaryLatch);
    end
    else
    begin
      pwmLevel = shownCount < state_ff.primaryLatch;
    end
    busAccess = psel && penable && state_ff.ready;
    busWrite = busAccess && pwrite && mapped(paddr);
    wrData = pwdata[15:0];
  end

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_state = state_ff;

    // apb: one wait cycle, answer registered
    nxt_state.ready = psel && penable && !state_ff.ready;
    nxt_state.slvErr = psel && penable && !state_ff.ready && !mapped(paddr);
    nxt_state.rdData = 32'h0000_0000;
    if (psel && penable && !state_ff.ready && !pwrite)
    begin
      case (paddr)
        OCP_OFS_CTRL_ONE: nxt_state.rdData = {16'h0000, state_ff.ctrlOne};
        OCP_OFS_CTRL_TWO: nxt_state.rdData = {16'h0000, state_ff.ctrlTwo};
        OCP_OFS_PRIMARY: nxt_state.rdData = {16'h0000, state_ff.primaryCompareReg};
        OCP_OFS_SECONDARY: nxt_state.rdData = {16'h0000, state_ff.secondaryCompareReg};
        OCP_OFS_PERIOD: nxt_state.rdData = {16'h0000, state_ff.timerPeriodReg};
        OCP_OFS_STATUS: nxt_state.rdData = {15'h0000, state_ff.faultState,
                                            state_ff.channelCount};
        default: nxt_state.rdData = 32'h0000_0000;
      endcase
    end

    if (busWrite)
    begin
      case (paddr)
        OCP_OFS_CTRL_ONE: nxt_state.ctrlOne = wrData & OCP_C1_WMASK;
        OCP_OFS_CTRL_TWO: nxt_state.ctrlTwo = wrData & OCP_C2_WMASK;
        OCP_OFS_PRIMARY: nxt_state.primaryCompareReg = wrData;
        OCP_OFS_SECONDARY: nxt_state.secondaryCompareReg = wrData;
        OCP_OFS_PERIOD: nxt_state.timerPeriodReg = wrData;
        default: nxt_state.ctrlOne = state_ff.ctrlOne;
      endcase
    end

    // hardware set wins over software clear
    if (faultHit[2])
    begin
      nxt_state.ctrlOne[OCP_C1_FLAG_COMP] = 1'b1;
    end
    if (faultHit[1])
    begin
      nxt_state.ctrlOne[OCP_C1_FLAG_PIN_B] = 1'b1;
    end
    if (faultHit[0])
    begin
      nxt_state.ctrlOne[OCP_C1_FLAG_PIN_A] = 1'b1;
    end

    // mode 000 holds the counter cleared
    if (modeField == OCP_MODE_OFF)
    begin
      nxt_state.channelCount = 16'h0000;
    end
    else if (periodMatch)
    begin
      nxt_state.channelCount = 16'h0000;
      nxt_state.primaryLatch = state_ff.primaryCompareReg;
      nxt_state.secondaryLatch = state_ff.secondaryCompareReg;
    end
    else if (running && timeTick)
    begin
      nxt_state.channelCount = state_ff.channelCount + 16'h0001;
    end

    case (state_ff.faultState)
      OCP_PWM_RUN:
      begin
        if (anyFault)
        begin
          nxt_state.faultState = OCP_FAULT_HOLD;
        end
      end
      OCP_FAULT_HOLD:
      begin
        if (!pwmMode)
        begin
          nxt_state.faultState = OCP_PWM_RUN;
        end
        else if (!anyFault)
        begin
          if (state_ff.ctrlTwo[OCP_C2_FAULT_EXIT])
          begin
            if (nxt_state.ctrlOne[OCP_C1_FLAG_COMP:OCP_C1_FLAG_PIN_A] == 3'h0)
            begin
              nxt_state.faultState = OCP_PWM_RUN;
            end
          end
          else if (periodMatch)
          begin
            nxt_state.faultState = OCP_PWM_RUN;
          end
        end
      end
      default: nxt_state.faultState = OCP_PWM_RUN;
    endcase

    if (!pwmMode)
    begin
      nxt_state.pinOut = 1'b0;
    end
    else if (nxt_state.faultState == OCP_FAULT_HOLD)
    begin
      nxt_state.pinOut = state_ff.ctrlTwo[OCP_C2_FAULT_LEVEL];
    end
    else if (periodMatch)
    begin
      // new period starts from count zero with fresh latches
      if (state_ff.secondaryCompareReg > state_ff.timerPeriodReg)
      begin
        nxt_state.pinOut = 1'b1;
      end
      else if (modeField == OCP_MODE_CENTER)
      begin
        nxt_state.pinOut = (state_ff.primaryCompareReg == 16'h0000) &&
                           (state_ff.secondaryCompareReg != 16'h0000);
      end
      else
      begin
        nxt_state.pinOut = state_ff.primaryCompareReg != 16'h0000;
      end
    end
    else
    begin
      nxt_state.pinOut = pwmLevel;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_ff <= '0;
      state_ff.ctrlTwo <= OCP_C2_RESET;
      state_ff.faultState <= OCP_PWM_RUN;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // outputs
  always_comb
  begin
    prdata = state_ff.rdData;
    pready = state_ff.ready;
    pslverr = state_ff.slvErr;
    compareOutputPin = state_ff.pinOut;
  end

endmodule

// ---- common/ocp_pkg.sv ----
// ocp_pkg: register map, field positions and codes of the pwm compare channel
// assumes: apb slave with 32-bit data, one word per register
package ocp_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OCP_OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OCP_OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OCP_OFS_PRIMARY = 8'h08;
  localparam logic [7:0] OCP_OFS_SECONDARY = 8'h0c;
  localparam logic [7:0] OCP_OFS_PERIOD = 8'h10;
  localparam logic [7:0] OCP_OFS_STATUS = 8'h14;

  // ==========================================================
  // compare_channel_control_one fields
  localparam int OCP_C1_IDLE_HALT = 13;
  localparam int OCP_C1_TSEL_LO = 10;
  localparam int OCP_C1_EN_COMP = 9;
  localparam int OCP_C1_EN_PIN_B = 8;
  localparam int OCP_C1_EN_PIN_A = 7;
  localparam int OCP_C1_FLAG_COMP = 6;
  localparam int OCP_C1_FLAG_PIN_B = 5;
  localparam int OCP_C1_FLAG_PIN_A = 4;
  localparam int OCP_C1_TRIG_CLEAR = 3;
  localparam logic [15:0] OCP_C1_WMASK = 16'h3fff;

  // ==========================================================
  // compare_channel_control_two fields
  localparam int OCP_C2_FAULT_EXIT = 15;
  localparam int OCP_C2_FAULT_LEVEL = 14;
  localparam int OCP_C2_TRIG_NOT_SYNC = 7;
  localparam logic [15:0] OCP_C2_WMASK = 16'hc09f;
  localparam logic [15:0] OCP_C2_RESET = 16'h000c;

  // ==========================================================
  // mode and time base codes
  localparam logic [2:0] OCP_MODE_OFF = 3'h0;
  localparam logic [2:0] OCP_MODE_EDGE = 3'h6;
  localparam logic [2:0] OCP_MODE_CENTER = 3'h7;
  localparam logic [2:0] OCP_TSEL_PERIPH = 3'h7;
  localparam logic [2:0] OCP_TSEL_TIMER1 = 3'h4;
  localparam logic [2:0] OCP_TSEL_TIMER5 = 3'h3;

  // ==========================================================
  // fault state
  typedef enum logic {OCP_PWM_RUN, OCP_FAULT_HOLD} ocp_fault_t;

endpackage

// ---- tb/ocp_pwm_chk.sv ----
// ocp_pwm_chk: port assertions for the pwm compare channel
// assumes: bound to channel index 1, so comparator 1 is its fault source
`timescale 1ns/1ps
module ocp_pwm_chk
  import ocp_pkg::*;
(
  // clock and apb
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // pin side
  input wire logic cpuIdle,
  input wire logic faultInputA,
  input wire logic faultInputB,
  input wire logic [2:0] comparatorOut,
  input wire logic compareOutputPin
);
  logic [15:0] ctrlOne_ff;
  logic level_ff;
  logic pwm;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ========
  // shadow of written control bits
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ctrlOne_ff <= 16'h0;
      level_ff <= 1'b0;
    end
    else if (psel && penable && pready && pwrite)
    begin
      if (paddr == OCP_OFS_CTRL_ONE)
        ctrlOne_ff <= pwdata[15:0];
      if (paddr == OCP_OFS_CTRL_TWO)
        level_ff <= pwdata[OCP_C2_FAULT_LEVEL];
    end
  end
  assign pwm = ctrlOne_ff[2:1] == 2'h3;
  sequence sAccess;
    psel && penable && !pready;
  endsequence
  sequence sHalted;
    cpuIdle && ctrlOne_ff[13] && pwm && !faultInputA && !faultInputB && !comparatorOut[0];
  endsequence
  // ========
  // assertions
  AST_APB_ANSWER: assert property (sAccess |=> pready)
    else $error("access not answered");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_IN_ACCESS: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  AST_FAULT_A: assert property (pwm && ctrlOne_ff[7] && faultInputA |=> compareOutputPin == level_ff)
    else $error("pin a fault level wrong");
  AST_FAULT_B: assert property (pwm && ctrlOne_ff[8] && faultInputB |=> compareOutputPin == level_ff)
    else $error("pin b fault level wrong");
  AST_FAULT_COMP: assert property (pwm && ctrlOne_ff[9] && comparatorOut[0] |=> compareOutputPin == level_ff)
    else $error("comparator fault level wrong");
  AST_NON_PWM_LOW: assert property (!pwm ##1 !pwm |-> !compareOutputPin)
    else $error("pin high outside pwm");
  AST_IDLE_HOLD: assert property (sHalted [*3] |-> $stable(compareOutputPin))
    else $error("pin moved while halted");
endmodule

// ---- tb/ocp_load_model.sv ----
// ocp_load_model: load on the pwm pin, counts high cycles and rising edges
// assumes: pin is a level synchronous to clock
`timescale 1ns/1ps
module ocp_load_model
(
  // clock
  input wire logic clock,
  // pin and measurement
  input wire logic pin,
  input wire logic clr,
  output logic [15:0] highCnt,
  output logic [15:0] riseCnt
);
  logic pinLast_ff;
  always_ff @(posedge clock)
  begin
    pinLast_ff <= pin;
    if (clr)
    begin
      highCnt <= 16'h0;
      riseCnt <= 16'h0;
    end
    else
    begin
      highCnt <= highCnt + {15'h0, pin};
      riseCnt <= riseCnt + {15'h0, pin && !pinLast_ff};
    end
  end
endmodule

// ---- tb/tb.sv ----
// tb: directed apb tests of the pwm compare channel
// assumes: channel index 1, clock 100 MHz
`timescale 1ns/1ps
module tb;
  import ocp_pkg::*;
  logic clock, reset_n, psel, penable, pwrite, pready, pslverr, cpuIdle, fA, fB, pin, clr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] tick = 4'h0;
  logic tickOne = 1'b0;
  logic [4:0] tickMask = 5'h0;
  logic [1:0] tickDiv = 2'h0;
  logic [2:0] comp;
  logic [15:0] highCnt, riseCnt;
  int fails, nTests, cyc;
  ocp_output_compare_pwm ocp_output_compare_pwm_inst (.clock(clock), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerPrescaleTick(tick),
    .timerOnePrescaleTick(tickOne), .cpuIdle(cpuIdle), .faultInputA(fA), .faultInputB(fB),
    .comparatorOut(comp), .compareOutputPin(pin));
  ocp_load_model ocp_load_model_inst (.clock(clock), .pin(pin), .clr(clr),
    .highCnt(highCnt), .riseCnt(riseCnt));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ========
  // timer ticks every fourth clock, and the timeout
  always @(posedge clock)
  begin
    tickDiv <= tickDiv + 2'h1;
    tick <= tickMask[3:0] & {4{tickDiv == 2'h0}};
    tickOne <= tickMask[4] && tickDiv == 2'h0;
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      giveVerdict();
    end
  end
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  task automatic pwmSet(input logic [15:0] p, input logic [15:0] a, input logic [15:0] b,
    input logic [15:0] c);
    wr(OCP_OFS_CTRL_ONE, 32'h0);
    wr(OCP_OFS_PERIOD, {16'h0, p});
    wr(OCP_OFS_PRIMARY, {16'h0, a});
    wr(OCP_OFS_SECONDARY, {16'h0, b});
    wr(OCP_OFS_CTRL_ONE, {16'h0, c});
    repeat (40) @(posedge clock);
  endtask
  // high count ffff skips that compare
  task automatic meas(input int n, input logic [15:0] h, input logic [15:0] r);
    @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (n) @(posedge clock);
    #1;
    if (h != 16'hffff)
      chk({16'h0, highCnt}, {16'h0, h});
    chk({16'h0, riseCnt}, {16'h0, r});
  endtask
  task automatic setFault(input int i, input logic v);
    case (i)
      0: fA <= v;
      1: fB <= v;
      default: comp[0] <= v;
    endcase
  endtask
  // ========
  // main sequence
  initial
  begin
    {reset_n, psel, penable, pwrite, cpuIdle, fA, fB, clr} = 8'h0;
    comp = 3'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rdc(OCP_OFS_CTRL_TWO, 32'hc);
    rdc(OCP_OFS_CTRL_ONE, 32'h0);
    xfer(8'h18, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(OCP_OFS_CTRL_TWO, 32'h1f);
    pwmSet(16'h7, 16'h3, 16'h0, 16'h1c06);
    meas(80, 16'd30, 16'd10);
    wr(OCP_OFS_PRIMARY, 32'h5);
    repeat (16) @(posedge clock);
    meas(80, 16'd50, 16'd10);
    pwmSet(16'h7, 16'h2, 16'h6, 16'h1c07);
    meas(80, 16'd40, 16'd10);
    pwmSet(16'h7, 16'h3, 16'h9, 16'h1c06);
    meas(80, 16'd80, 16'd0);
    pwmSet(16'h0, 16'h0, 16'h0, 16'h1c06);
    meas(80, 16'd0, 16'd0);
    for (int i = 0; i < 6; i++)
    begin
      tickMask <= (i == 4) ? 5'h10 : (i == 5) ? 5'h1f : 5'h1 << i;
      pwmSet(16'h7, 16'h3, 16'h0, {3'h0, 3'(i), 10'h6});
      meas(128, (i < 5) ? 16'd48 : 16'hffff, (i < 5) ? 16'd4 : 16'd0);
    end
    pwmSet(16'h7, 16'h3, 16'h0, 16'h3c06);
    cpuIdle <= 1'b1;
    meas(40, 16'hffff, 16'd0);
    wr(OCP_OFS_CTRL_ONE, 32'h1c06);
    meas(40, 16'd15, 16'd5);
    cpuIdle <= 1'b0;
    // compare interrupt enable sits outside this block
    for (int i = 0; i < 3; i++)
    begin
      wr(OCP_OFS_CTRL_TWO, {16'h0, i == 2, i != 1, 14'h1f});
      wr(OCP_OFS_CTRL_ONE, {16'h0, 16'h1c06 | (16'h80 << i)});
      setFault(i, 1'b1);
      meas(16, (i != 1) ? 16'd16 : 16'd0, 16'd0);
      setFault(i, 1'b0);
      repeat (16) @(posedge clock);
      meas(16, (i == 2) ? 16'd16 : 16'd6, (i == 2) ? 16'd0 : 16'd2);
      rdc(OCP_OFS_CTRL_ONE, {16'h0, 16'h1c06 | (16'h90 << i)});
    end
    wr(OCP_OFS_CTRL_ONE, 32'h80);
    fA <= 1'b1;
    repeat (4) @(posedge clock);
    rdc(OCP_OFS_CTRL_ONE, 32'h80);
    rdc(OCP_OFS_STATUS, 32'h0);
    giveVerdict();
  end
endmodule
bind ocp_output_compare_pwm ocp_pwm_chk ocp_pwm_chk_inst (.clock(clock), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .cpuIdle(cpuIdle), .faultInputA(faultInputA),
  .faultInputB(faultInputB), .comparatorOut(comparatorOut),
  .compareOutputPin(compareOutputPin));
